// ===== pkg/dac_host_pkg.sv
// Shared constants and types for the converter host controller.
// Assumes a 10 MHz clk and a left-justified 10-bit double-buffered converter.
package dac_host_pkg;

    // Register byte offsets on the Avalon-MM slave
    localparam logic [3:0] OFF_CTRL   = 4'h0;
    localparam logic [3:0] OFF_DATA   = 4'h4;
    localparam logic [3:0] OFF_UPDATE = 4'h8;
    localparam logic [3:0] OFF_STATUS = 4'hC;

    // Field positions
    localparam int MODE_LSB      = 0;
    localparam int CODE_LSB      = 0;
    localparam int STAT_BUSY     = 0;
    localparam int STAT_LOADED   = 1;
    localparam int STAT_DAC_LSB  = 16;
    localparam int CODE_W        = 10;
    localparam int LOW_PAIR_LSB  = 6;

    // Bus attachment and transfer options
    typedef enum logic [2:0] {
        MODE_AUTO8     = 3'b000,
        MODE_HOST8     = 3'b001,
        MODE_EXT8      = 3'b010,
        MODE_SINGLE16  = 3'b011,
        MODE_DOUBLE16  = 3'b100
    } mode_t;

    localparam mode_t MODE_RESET = MODE_AUTO8;

    // Pin cycle sequencer
    typedef enum logic [1:0] {
        SEQ_IDLE   = 2'b00,
        SEQ_FIRST  = 2'b01,
        SEQ_SECOND = 2'b10,
        SEQ_UPDATE = 2'b11
    } seq_t;

    // Phases of one write cycle on the pins
    typedef enum logic [1:0] {
        PH_IDLE   = 2'b00,
        PH_SETUP  = 2'b01,
        PH_STROBE = 2'b10,
        PH_HOLD   = 2'b11
    } phase_t;

    // Write cycle timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int WR_SETUP_NS   = 200;
    localparam int WR_PULSE_NS   = 500;
    localparam int WR_HOLD_NS    = 200;
    localparam logic [3:0] SETUP_CYC =
        4'((WR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [3:0] PULSE_CYC =
        4'((WR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    // At least two: the strobe output lags the phase by one register stage
    localparam logic [3:0] HOLD_CYC =
        4'(((WR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 2 ? 2 :
           ((WR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS));

    // Converter pins, all driven by the host
    typedef struct packed {
        logic        cs_n;
        logic        wr_n;
        logic        byte_select;
        logic        transfer_strobe_n;
        logic [15:0] data;
    } dac_pins_t;

    localparam dac_pins_t PINS_RESET = '{cs_n: 1'b1, wr_n: 1'b1, byte_select: 1'b1,
                                         transfer_strobe_n: 1'b1, data: 16'h0000};

endpackage : dac_host_pkg

// ===== rtl/dac_write_timer.sv
// One write cycle on the converter pins: setup, strobe low, hold.
// Assumes start is a one-cycle pulse given only while the timer is idle.
`timescale 1ns/1ns
module dac_write_timer (
    input  wire logic clk,
    input  wire logic reset_n,
    input  wire logic start,
    output logic      strobe,
    output logic      done
);
    import dac_host_pkg::*;

    typedef struct packed {
        phase_t     phase;
        logic [3:0] count;
        logic       strobe;
        logic       done;
    } timer_state_t;

    timer_state_t s;
    timer_state_t next_s;

    always_comb begin
        next_s      = s;
        next_s.done = 1'b0;
        case (s.phase)
            PH_IDLE: begin
                if (start) begin
                    next_s.phase = PH_SETUP;
                    next_s.count = SETUP_CYC - 4'h1;
                end
            end
            PH_SETUP: begin
                if (s.count == 4'h0) begin
                    next_s.phase  = PH_STROBE;
                    next_s.count  = PULSE_CYC - 4'h1;
                    next_s.strobe = 1'b1;
                end else begin
                    next_s.count = s.count - 4'h1;
                end
            end
            PH_STROBE: begin
                if (s.count == 4'h0) begin
                    next_s.phase  = PH_HOLD;
                    next_s.count  = HOLD_CYC - 4'h1;
                    next_s.strobe = 1'b0;
                end else begin
                    next_s.count = s.count - 4'h1;
                end
            end
            PH_HOLD: begin
                if (s.count == 4'h0) begin
                    next_s.phase = PH_IDLE;
                    next_s.done  = 1'b1;
                end else begin
                    next_s.count = s.count - 4'h1;
                end
            end
            default: begin
                next_s.phase = PH_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            s <= '{phase: PH_IDLE, count: 4'h0, strobe: 1'b0, done: 1'b0};
        end else begin
            s <= next_s;
        end
    end

    assign strobe = s.strobe;
    assign done   = s.done;

endmodule : dac_write_timer

// ===== rtl/dac_host_ctrl.sv
// Host controller that drives a double-buffered 10-bit converter over its pins.
// Assumes software on an Avalon-MM master; converter input latch and DAC
// register live outside and obey chip select, write, byte select and transfer.
`timescale 1ns/1ns

// Overview of operation
// RQ1: Eight-bit bus sends code in two writes
// RQ2: Device loads all bits first, pair second
// RQ3: Host sends high group first, low second
// RQ4: Auto mode: first byte captured first strobe
// RQ5: Auto mode: second write loads and transfers
// RQ6: Host mode: third strobe performs the transfer
// RQ7: External mode: outside logic strobes the transfer
// RQ8: Output changes only on register transfer
// RQ9: Auto for lone converters, strobes for many
// RQ10: Wide bus: bits six to fifteen, select high
// RQ11: Wide bus: single or double buffered only
// RQ12: Stand-alone flow-through passes data straight through; mode_ok refuses flow-through on this controller
// RQ13: Transfer low follows latch, high holds
// RQ14: Register frozen once transfer returns high
// RQ15: Select and transfer follow address bit zero
// RQ16: Chip select spans both write strobes
// RQ17: Incrementing double store needs odd address
// RQ18: Strobes without chip select change nothing
module dac_host_ctrl (
    input  wire logic                    clk,
    input  wire logic                    reset_n,
    input  wire logic [3:0]              address,
    input  wire logic                    read,
    input  wire logic                    write,
    input  wire logic [31:0]             writedata,
    input  wire logic [3:0]              byteenable,
    output logic      [31:0]             readdata,
    output logic                         waitrequest,
    output dac_host_pkg::dac_pins_t      dac_pins
);
    import dac_host_pkg::*;

    typedef struct packed {
        logic        waitrequest;
        logic [31:0] readdata;
        mode_t       mode;
        logic [9:0]  code;
        logic [9:0]  dac_code;
        logic        loaded;
        seq_t        seq;
        logic        start;
        dac_pins_t   pins;
    } host_state_t;

    host_state_t s;
    host_state_t next_s;

    logic timer_strobe;
    logic timer_done;

    // Whole 10-bit word in one write on the wide bus
    function automatic logic is_wide(input mode_t m);
        is_wide = (m == MODE_SINGLE16) || (m == MODE_DOUBLE16);
    endfunction : is_wide

    // Only these modes accept a separate transfer command
    function automatic logic takes_update(input mode_t m);
        takes_update = (m == MODE_HOST8) || (m == MODE_DOUBLE16);
    endfunction : takes_update

    // Flow-through and unknown codes are not offered
    function automatic logic mode_ok(input logic [2:0] m);
        case (m)
            MODE_AUTO8, MODE_HOST8, MODE_EXT8, MODE_SINGLE16, MODE_DOUBLE16: begin
                mode_ok = 1'b1;
            end
            default: begin
                mode_ok = 1'b0;
            end
        endcase
    endfunction : mode_ok

    // Bus lines for the cycle about to be run
    function automatic logic [15:0] bus_word(input mode_t m, input seq_t q,
                                             input logic [9:0] c);
        logic [15:0] w;
        w = 16'h0000;
        if (q == SEQ_FIRST && is_wide(m)) begin
            w = {c, 6'h00};                                     // see RQ10
        end else if (q == SEQ_FIRST) begin
            w = {8'h00, c[9:2]};                                // see RQ3
        end else if (q == SEQ_SECOND) begin
            w = {8'h00, c[1:0], 6'h00};                         // see RQ3
        end
        bus_word = w;
    endfunction : bus_word

    // Per-lane merge of a write into a stored word
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[8*i +: 8] = wd[8*i +: 8];
            end
        end
        merge = r;
    endfunction : merge

    dac_write_timer u_timer (
        .clk     (clk),
        .reset_n (reset_n),
        .start   (s.start),
        .strobe  (timer_strobe),
        .done    (timer_done)
    );

    always_comb begin
        logic        busy;
        logic        stall;
        logic [31:0] word;
        logic [31:0] status;
        busy   = 1'b0;
        stall  = 1'b0;
        word   = 32'h0000_0000;
        status = 32'h0000_0000;

        next_s       = s;
        next_s.start = 1'b0;

        busy = (s.seq != SEQ_IDLE);
        // Pin cycles cannot be reordered, so new data and update writes wait for the pins
        stall = busy && (address == OFF_DATA || address == OFF_UPDATE) && write;

        status[STAT_BUSY]                    = busy;
        status[STAT_LOADED]                  = s.loaded;
        status[STAT_DAC_LSB +: CODE_W]       = s.dac_code;

        // Sequencer advances when a write cycle ends
        if (timer_done) begin
            case (s.seq)
                SEQ_FIRST: begin
                    if (s.mode == MODE_SINGLE16) begin
                        next_s.seq      = SEQ_IDLE;
                        next_s.dac_code = s.code;                   // see RQ10
                        next_s.loaded   = 1'b0;
                    end else if (s.mode == MODE_DOUBLE16) begin
                        // Held in the input latch for a joint update
                        next_s.seq    = SEQ_IDLE;                   // see RQ11
                        next_s.loaded = 1'b1;
                    end else begin
                        next_s.seq   = SEQ_SECOND;                  // see RQ1
                        next_s.start = 1'b1;
                    end
                end
                SEQ_SECOND: begin
                    next_s.seq = SEQ_IDLE;
                    if (s.mode == MODE_AUTO8) begin
                        next_s.dac_code = s.code;                   // see RQ5
                        next_s.loaded   = 1'b0;
                    end else begin
                        // Output stays put until a transfer happens
                        next_s.loaded = 1'b1;                       // see RQ8
                    end
                end
                SEQ_UPDATE: begin
                    next_s.seq      = SEQ_IDLE;
                    next_s.dac_code = s.code;                       // see RQ14
                    next_s.loaded   = 1'b0;
                end
                default: begin
                    next_s.seq = SEQ_IDLE;
                end
            endcase
        end

        // Avalon slave: answer one cycle after the request, commit on that edge
        if (!s.waitrequest) begin
            next_s.waitrequest = 1'b1;
            if (write) begin
                case (address)
                    OFF_CTRL: begin
                        word = merge({29'h0, s.mode}, writedata, byteenable);
                        if (mode_ok(word[MODE_LSB +: 3])) begin     // see RQ11
                            next_s.mode = mode_t'(word[MODE_LSB +: 3]);
                        end
                    end
                    OFF_DATA: begin
                        word = merge({22'h0, s.code}, writedata, byteenable);
                        next_s.code  = word[CODE_LSB +: CODE_W];
                        next_s.seq   = SEQ_FIRST;
                        next_s.start = 1'b1;
                    end
                    OFF_UPDATE: begin
                        // Ignored where the converter updates by itself or outside logic strobes the transfer
                        if (takes_update(s.mode)) begin             // see RQ6
                            next_s.seq   = SEQ_UPDATE;
                            next_s.start = 1'b1;
                        end
                    end
                    default: begin
                        next_s.seq = next_s.seq;
                    end
                endcase
            end
        end else if ((read || write) && !stall) begin
            next_s.waitrequest = 1'b0;
            next_s.readdata    = 32'h0000_0000;
            if (read) begin
                case (address)
                    OFF_CTRL:   next_s.readdata = {29'h0, s.mode};
                    OFF_DATA:   next_s.readdata = {22'h0, s.code};
                    OFF_STATUS: next_s.readdata = status;
                    default:    next_s.readdata = 32'h0000_0000;
                endcase
            end
        end

        // Pin levels for the coming cycle
        // Chip select covers the whole of both data writes
        next_s.pins.cs_n = !(next_s.seq == SEQ_FIRST ||
                             next_s.seq == SEQ_SECOND);             // see RQ16
        // Select high on the first write, low on the second, as address bit 0
        next_s.pins.byte_select = (next_s.seq != SEQ_SECOND);       // see RQ15, see RQ17
        // Transfer rides the second write in auto mode, never in external mode
        next_s.pins.transfer_strobe_n =
            !((next_s.seq == SEQ_SECOND && next_s.mode == MODE_AUTO8) ||  // see RQ4
              (next_s.seq == SEQ_FIRST && next_s.mode == MODE_SINGLE16) ||
              next_s.seq == SEQ_UPDATE);                                  // see RQ7, see RQ13
        // Transfer-only strobe leaves chip select off so the latch stays put
        next_s.pins.wr_n = !(timer_strobe && next_s.seq != SEQ_IDLE);    // see RQ18
        next_s.pins.data = bus_word(next_s.mode, next_s.seq, next_s.code); // see RQ2
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            s <= '{waitrequest: 1'b1, readdata: 32'h0000_0000, mode: MODE_RESET,
                   code: 10'h000, dac_code: 10'h000, loaded: 1'b0, seq: SEQ_IDLE,
                   start: 1'b0, pins: PINS_RESET};
        end else begin
            s <= next_s;
        end
    end

    // Strobe mode choice: auto for a lone converter, host or external for groups
    assign readdata    = s.readdata;                                // see RQ9
    assign waitrequest = s.waitrequest;
    assign dac_pins    = s.pins;

    // Flow-through needs no host; mode_ok refuses it on this controller
    // so that the converter always sees a latched word.                see RQ12

endmodule : dac_host_ctrl

// ===== sim/dac_host_ctrl_checker.sv
// Port-level checks for the converter host controller.
// Assumes it is bound onto dac_host_ctrl; one clock, synchronous reset.
`timescale 1ns/1ns
module dac_host_ctrl_checker (
    input wire logic                     clk,
    input wire logic                     reset_n,
    input wire logic [3:0]               address,
    input wire logic                     read,
    input wire logic                     write,
    input wire logic [31:0]              readdata,
    input wire logic                     waitrequest,
    input wire dac_host_pkg::dac_pins_t  dac_pins
);
    import dac_host_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    property p_ack_once;
        !waitrequest |=> waitrequest;
    endproperty
    a_ack_once: assert property (p_ack_once)
        else $error("waitrequest low longer than one cycle");
    property p_ack_bound;
        (read || write) && waitrequest |-> ##[1:40] !waitrequest;
    endproperty
    a_ack_bound: assert property (p_ack_bound)
        else $error("bus request never answered");
    property p_unmapped;
        read && address[1:0] != 2'h0 && !waitrequest |-> readdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
    property p_pulse;
        $fell(dac_pins.wr_n) |-> !dac_pins.wr_n [*5] ##1 dac_pins.wr_n;
    endproperty
    a_pulse: assert property (p_pulse)
        else $error("write strobe width wrong");
    property p_setup;
        $fell(dac_pins.cs_n) |-> dac_pins.wr_n [*4];
    endproperty
    a_setup: assert property (p_setup)
        else $error("strobe too soon after select");
    property p_steady;
        !dac_pins.wr_n |=> $stable(dac_pins.data) && $stable(dac_pins.byte_select)
            && $stable(dac_pins.transfer_strobe_n) && $stable(dac_pins.cs_n);
    endproperty
    a_steady: assert property (p_steady)
        else $error("pins moved around strobe");
    property p_cs_span;
        $fell(dac_pins.cs_n) |-> !dac_pins.cs_n [*8];
    endproperty
    a_cs_span: assert property (p_cs_span)
        else $error("select released too early");
    property p_pair;
        $fell(dac_pins.byte_select) |-> !dac_pins.cs_n && !$past(dac_pins.cs_n);
    endproperty
    a_pair: assert property (p_pair)
        else $error("second byte not after first");
    property p_latch_cs;
        !dac_pins.wr_n && dac_pins.transfer_strobe_n |-> !dac_pins.cs_n;
    endproperty
    a_latch_cs: assert property (p_latch_cs)
        else $error("latch strobe without select");
endmodule : dac_host_ctrl_checker

bind dac_host_ctrl dac_host_ctrl_checker chk_u (.clk(clk), .reset_n(reset_n),
    .address(address), .read(read), .write(write), .readdata(readdata),
    .waitrequest(waitrequest), .dac_pins(dac_pins));

// ===== sim/dac_conv_model.sv
// Behavioural converter digital section: input latch and DAC register.
// Assumes pins from the host block; wide picks the 16-bit wiring.
`timescale 1ns/1ns
module dac_conv_model (
    input wire dac_host_pkg::dac_pins_t  pins,
    input wire logic                     wide,
    input wire logic                     ext_update_n,
    output logic [9:0]                   in_latch,
    output logic [9:0]                   dac_reg
);
    import dac_host_pkg::*;
    wire ld = !pins.cs_n && !pins.wr_n;
    wire xf = (!pins.transfer_strobe_n && !pins.wr_n) || !ext_update_n;

    // Transparent latches: both buffers are level sensitive
    always @* begin
        if (ld && pins.byte_select) begin
            in_latch = wide ? pins.data[15:6] : {pins.data[7:0], pins.data[7:6]};
        end else if (ld) begin
            in_latch[1:0] = pins.data[7:6];
        end
    end
    always @* begin
        if (xf) begin
            dac_reg = in_latch;
        end
    end
endmodule : dac_conv_model

// ===== sim/tb_dac_host_ctrl.sv
// Self-checking bench for the converter host controller.
// Assumes the converter model and the bound checker are compiled alongside.
`timescale 1ns/1ns
module tb_dac_host_ctrl;
    import dac_host_pkg::*;
    logic        clk, reset_n, read, write, wide, ext_update_n;
    logic [3:0]  address, byteenable;
    logic [31:0] writedata, readdata, rd;
    logic        waitrequest;
    dac_pins_t   pins;
    logic [9:0]  in_latch, dac_reg, exp_dac;
    int          n_mismatch, check_count, cycles, seed;

    dac_host_ctrl dut_u (.clk(clk), .reset_n(reset_n), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(byteenable),
        .readdata(readdata), .waitrequest(waitrequest), .dac_pins(pins));
    dac_conv_model conv_u (.pins(pins), .wide(wide), .ext_update_n(ext_update_n),
        .in_latch(in_latch), .dac_reg(dac_reg));

    always #50 clk = ~clk;

    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : close_out

    // Ceiling well above the several hundred cycles the sequence needs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            close_out();
        end
    end

    task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, e, g);
        end
    endtask : check

    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        address   <= a;
        writedata <= d;
        write     <= wr;
        read      <= !wr;
        do @(posedge clk); while (waitrequest !== 1'b0);
        rd = readdata;
        write <= 1'b0;
        read  <= 1'b0;
        @(posedge clk);
    endtask : bus

    task automatic wait_idle();
        for (int i = 0; i < 60; i++) begin
            bus(1'b0, OFF_STATUS, 32'h0);
            if (rd[STAT_BUSY] === 1'b0) break;
        end
    endtask : wait_idle

    // Modes in which the data write alone moves the word into the DAC register
    function automatic logic updates_on_data(input mode_t md);
        return (md == MODE_AUTO8) || (md == MODE_SINGLE16);
    endfunction : updates_on_data

    task automatic run_mode(input mode_t md, input logic [9:0] c);
        logic host;
        host = (md == MODE_HOST8) || (md == MODE_DOUBLE16);
        wide <= (md >= MODE_SINGLE16);
        bus(1'b1, OFF_CTRL, 32'(md));
        bus(1'b1, OFF_DATA, 32'(c));
        wait_idle();
        check("latch", 32'(c), 32'(in_latch));
        if (updates_on_data(md)) exp_dac = c;
        check("dac before transfer", 32'(exp_dac), 32'(dac_reg));
        if (md == MODE_EXT8) begin
            ext_update_n <= 1'b0;
            @(posedge clk);
            ext_update_n <= 1'b1;
            @(posedge clk);
            exp_dac = c;
        end else begin
            // Ignored in auto and single-buffered modes
            bus(1'b1, OFF_UPDATE, 32'h0);
            wait_idle();
            if (host) exp_dac = c;
            check("status code", 32'(exp_dac), 32'(rd[25:16]));
            check("status loaded", 32'h0, 32'(rd[STAT_LOADED]));
        end
        check("dac after transfer", 32'(exp_dac), 32'(dac_reg));
    endtask : run_mode

    initial begin
        seed = 42969;
        clk = 1'b0;
        reset_n = 1'b0;
        {read, write, address, writedata} = '0;
        byteenable = 4'hF;
        wide = 1'b0;
        ext_update_n = 1'b1;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        check("pins idle", 32'(PINS_RESET), 32'(pins));
        bus(1'b0, OFF_CTRL, 32'h0);
        check("ctrl reset", 32'h0, rd);
        bus(1'b0, OFF_STATUS, 32'h0);
        check("status reset", 32'h0, rd);
        for (int r = 0; r < 3; r++) begin
            for (int k = 0; k < 5; k++) begin
                run_mode(mode_t'(k), r == 0 ? (k[0] ? 10'h3FF : 10'h001)
                                            : 10'($random(seed)));
            end
        end
        bus(1'b1, OFF_CTRL, 32'h5);
        bus(1'b0, OFF_CTRL, 32'h0);
        check("bad mode ignored", 32'(MODE_DOUBLE16), 32'(rd[2:0]));
        // Lane 0 masked off, so the mode field must keep its old value
        byteenable <= 4'hE;
        bus(1'b1, OFF_CTRL, 32'h1);
        byteenable <= 4'hF;
        bus(1'b0, OFF_CTRL, 32'h0);
        check("masked mode write", 32'(MODE_DOUBLE16), 32'(rd[2:0]));
        bus(1'b1, 4'h6, 32'h3FF);
        bus(1'b0, 4'h2, 32'h0);
        check("unmapped read", 32'h0, rd);
        check("dac unchanged", 32'(exp_dac), 32'(dac_reg));
        close_out();
    end
endmodule : tb_dac_host_ctrl
